// ===== logic/crbt_ctrl_end.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// controller end: initiates transfers and decodes replies
// ****************************************
module crbt_ctrl_end (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ce,
    crbt_if.ctl bus,
    input wire logic [15:0] tx_data,
    input wire logic tx_cmd,
    input wire logic tx_valid,
    output logic tx_ready_q,
    output logic rx_valid_q,
    output logic [15:0] rx_word_q,
    output logic rx_cmd_q,
    output logic rx_par_ok_q
);
    logic rp_s1_q, rp_s2_q, rn_s1_q, rn_s2_q; // line synchronisers
    logic lvl_q, act_q; // previous level and activity
    logic [8:0] run_q; // constant-run length
    crbt_pkg::crbt_rx_e rx_q; // decoder state
    logic [8:0] cnt_q; // sample timer
    logic [4:0] nbit_q; // bits taken
    logic [16:0] sh_q; // payload and parity
    logic kind_q; // command sync seen
    logic busy_q; // transmitter running
    logic [39:0] sym_q; // half-bit symbols
    logic [5:0] left_q; // halves left
    logic [8:0] hcnt_q; // cycles left in half
    logic pos_q, neg_q, oe_n_q; // pin registers
    wire lvl = rp_s2_q;
    wire act = rp_s2_q | rn_s2_q;
    wire trans = act & act_q & (lvl ^ lvl_q);
    wire same = act & act_q & ~(lvl ^ lvl_q);
    wire sync_seen = trans & (run_q >= `CRBT_SYNC_MIN_CNT) & ~busy_q;
    wire wdone = (rx_q == crbt_pkg::CRBT_RX_MID) & trans & (nbit_q == `CRBT_WORD_BITS);
    // the controller may start at will, but never over traffic; ready is a register, so
    // it reflects last cycle's view of the line: one extra cycle of collision window
    wire can_go = ~busy_q & (rx_q == crbt_pkg::CRBT_RX_IDLE) & ~act & ~act_q;
    wire go = tx_valid & tx_ready_q;
    // synchronisers and run length
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            {rp_s1_q, rp_s2_q, rn_s1_q, rn_s2_q, lvl_q, act_q} <= 6'h00;
            run_q <= '0;
        end else if (ce) begin
            rp_s1_q <= bus.line_pos;
            rp_s2_q <= rp_s1_q;
            rn_s1_q <= bus.line_neg;
            rn_s2_q <= rn_s1_q;
            lvl_q <= lvl;
            act_q <= act;
            run_q <= !same ? 9'h0 : (run_q == `CRBT_RUN_MAX) ? run_q : run_q + 9'h1;
        end
    end
    // decoder, re-timed at every mid-bit crossing
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rx_q <= crbt_pkg::CRBT_RX_IDLE;
            {cnt_q, nbit_q, sh_q, kind_q} <= '0;
        end else if (ce) begin
            unique case (rx_q)
                crbt_pkg::CRBT_RX_IDLE: if (sync_seen) begin
                    kind_q <= lvl_q;
                    cnt_q <= `CRBT_SKIP_CNT;
                    nbit_q <= '0;
                    rx_q <= crbt_pkg::CRBT_RX_SAMP;
                end
                crbt_pkg::CRBT_RX_SAMP: if (cnt_q == '0) begin
                    sh_q <= {sh_q[15:0], lvl};
                    nbit_q <= nbit_q + 5'h1;
                    cnt_q <= `CRBT_MID_WIN_CNT;
                    rx_q <= crbt_pkg::CRBT_RX_MID;
                end else begin
                    cnt_q <= cnt_q - 9'h1;
                end
                crbt_pkg::CRBT_RX_MID: if (trans) begin
                    cnt_q <= `CRBT_RESYNC_CNT;
                    rx_q <= wdone ? crbt_pkg::CRBT_RX_IDLE : crbt_pkg::CRBT_RX_SAMP;
                end else if (cnt_q == '0) begin
                    rx_q <= crbt_pkg::CRBT_RX_IDLE;
                end else begin
                    cnt_q <= cnt_q - 9'h1;
                end
                default: rx_q <= crbt_pkg::CRBT_RX_IDLE;
            endcase
        end
    end
    // reply reports and registered ready
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            {rx_valid_q, rx_word_q, rx_cmd_q, rx_par_ok_q} <= '0;
            tx_ready_q <= 1'b0;
        end else if (ce) begin
            rx_valid_q <= wdone;
            if (wdone) begin
                rx_word_q <= sh_q[16:1];
                rx_cmd_q <= kind_q;
                rx_par_ok_q <= ^sh_q;
            end
            tx_ready_q <= can_go & ~go;
        end
    end
    // encoder from the local clock
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
            {sym_q, left_q, hcnt_q} <= '0;
            {pos_q, neg_q} <= 2'b00;
            oe_n_q <= 1'b1;
        end else if (ce) begin
            if (go) begin
                sym_q <= crbt_pkg::crbt_encode(tx_data, tx_cmd);
                left_q <= `CRBT_SYMS;
                hcnt_q <= `CRBT_HALF_CNT;
                busy_q <= 1'b1;
            end else if (busy_q && hcnt_q == '0) begin
                sym_q <= {sym_q[38:0], 1'b0};
                left_q <= left_q - 6'h1;
                hcnt_q <= `CRBT_HALF_CNT;
                busy_q <= left_q != 6'h1;
            end else if (busy_q) begin
                hcnt_q <= hcnt_q - 9'h1;
            end
            pos_q <= busy_q & sym_q[39];
            neg_q <= busy_q & ~sym_q[39];
            oe_n_q <= ~busy_q;
        end
    end
    assign bus.ctl_pos = pos_q;
    assign bus.ctl_neg = neg_q;
    assign bus.ctl_oe_n = oe_n_q;
endmodule
`default_nettype wire

// ===== logic/crbt_defines.svh
`ifndef CRBT_DEFINES_SVH
`define CRBT_DEFINES_SVH
// ****************************************
// timing, all derived from the core clock
// ****************************************
`define CRBT_CLK_PERIOD_NS 4
`define CRBT_BIT_TIME_NS 1000
`define CRBT_BIT_CYC (`CRBT_BIT_TIME_NS / `CRBT_CLK_PERIOD_NS)
`define CRBT_HALF_CNT 9'((`CRBT_BIT_CYC / 2) - 1)
`define CRBT_SYNC_MIN_CNT 9'((`CRBT_BIT_CYC * 5) / 4)
`define CRBT_SKIP_CNT 9'(((`CRBT_BIT_CYC * 3) / 2) + (`CRBT_BIT_CYC / 4))
`define CRBT_RESYNC_CNT 9'((`CRBT_BIT_CYC * 3) / 4)
`define CRBT_MID_WIN_CNT 9'(`CRBT_BIT_CYC / 2)
`define CRBT_RUN_MAX 9'h1FF
// ****************************************
// word layout
// ****************************************
`define CRBT_WORD_BITS 5'h11
`define CRBT_SYMS 6'h28
`define CRBT_SYNC_CMD 6'h38
`define CRBT_SYNC_DATA 6'h07
`define CRBT_BCAST_ADDR 5'h1F
`define CRBT_MODE_SA0 5'h00
`define CRBT_MODE_SA1 5'h1F
`define CRBT_DBC_CODE 5'h00
`define CRBT_MAX_WORDS 6'h20
`endif

// ===== logic/crbt_fifo.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// small word fifo, registered ready and valid
// ****************************************
module crbt_fifo #(
    parameter int W = 17,
    parameter int D = 16
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D]; // storage
    logic [AW-1:0] wp_q; // write pointer
    logic [AW-1:0] rp_q; // read pointer
    logic [AW:0] cnt_q; // words held
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    wire [AW:0] cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data = mem[rp_q];
    // pointers and flags; flags are registered from the next count
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else if (ce) begin
            if (push) wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
            if (pop) rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
            cnt_q <= cnt_d;
            in_ready <= cnt_d != (AW+1)'(D);
            out_valid <= cnt_d != '0;
        end
    end
    // storage write, no reset needed
    always_ff @(posedge core_clk) begin
        if (ce && push) mem[wp_q] <= in_data;
    end
endmodule
`default_nettype wire

// ===== logic/crbt_if.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// shared bus pair: each end drives its own copy, the line is the wired result
// ****************************************
interface crbt_if;
    logic dev_pos; // terminal drive, positive leg
    logic dev_neg; // terminal drive, negative leg
    logic dev_oe_n; // terminal drives while low
    logic ctl_pos; // controller end drive, positive leg
    logic ctl_neg; // controller end drive, negative leg
    logic ctl_oe_n; // controller end drives while low
    logic line_pos; // resolved positive leg
    logic line_neg; // resolved negative leg
    // both legs low means nobody is driving
    assign line_pos = (~dev_oe_n & dev_pos) | (~ctl_oe_n & ctl_pos);
    assign line_neg = (~dev_oe_n & dev_neg) | (~ctl_oe_n & ctl_neg);
    modport dev (output dev_pos, output dev_neg, output dev_oe_n,
                 input line_pos, input line_neg);
    modport ctl (output ctl_pos, output ctl_neg, output ctl_oe_n,
                 input line_pos, input line_neg);
endinterface
`default_nettype wire

// ===== logic/crbt_pkg.sv
`include "crbt_defines.svh"
package crbt_pkg;
    // terminal role; code 2'b11 is folded onto the remote unit
    typedef enum logic [1:0] {
        CRBT_ROLE_RU = 2'b00,
        CRBT_ROLE_BC = 2'b01,
        CRBT_ROLE_MON = 2'b10
    } crbt_role_e;
    // receive decoder states
    typedef enum logic [1:0] {
        CRBT_RX_IDLE = 2'b00,
        CRBT_RX_SAMP = 2'b01,
        CRBT_RX_MID = 2'b10
    } crbt_rx_e;
    // builds the 40 half-bit symbols of one word, first symbol in bit 39
    function automatic logic [39:0] crbt_encode(input logic [15:0] w, input logic cmd);
        logic [39:0] s;
        logic p;
        s = 40'h0;
        p = ~^w;
        s[39:34] = cmd ? `CRBT_SYNC_CMD : `CRBT_SYNC_DATA;
        for (int i = 0; i < 16; i++) begin
            s[33 - 2 * i] = w[15 - i];
            s[32 - 2 * i] = ~w[15 - i];
        end
        s[1] = p;
        s[0] = ~p;
        return s;
    endfunction
endpackage

// ===== logic/crbt_terminal.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// - each word is sync, sixteen bits, parity
// - only command, status and data words exist
// - message: command, status, data when called
// - remote-to-remote: two commands, two statuses, data
// - half duplex, never transmit while receiving
// - bus controller alone initiates every transfer
// - remote unit transmits only when commanded
// - own clock out, recovered timing in
// - broadcast address reaches several remote units
// - accepted bus control offer makes controller
// - monitor listens passively and captures words
// - mode codes address terminal hardware only
// - neither controller nor monitor means remote unit
// - manchester: one high-low, zero low-high
// - one bit lasts one microsecond
// - last bit is odd parity
// - command sync high then low, three bits
module crbt_terminal #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ce,
    crbt_if.dev bus,
    input wire logic [1:0] role_sel,
    input wire logic role_set,
    input wire logic [4:0] my_addr,
    input wire logic bcast_en,
    input wire logic dbc_accept,
    input wire logic [15:0] in_data,
    input wire logic in_cmd,
    input wire logic in_valid,
    output logic in_ready,
    output logic rx_valid_q,
    output logic [15:0] rx_word_q,
    output logic rx_cmd_q,
    output logic rx_par_ok_q,
    output logic mode_stb_q,
    output logic [4:0] mode_code_q,
    output logic [1:0] role_now_q
);
    // ****************************************
    // line synchronisers
    // ****************************************
    logic rp_s1_q, rp_s2_q, rn_s1_q, rn_s2_q; // two stages per leg
    logic lvl_q, act_q; // previous sampled level and activity
    logic [8:0] run_q; // length of the current constant run
    // the line is another domain; first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            {rp_s1_q, rp_s2_q, rn_s1_q, rn_s2_q} <= 4'h0;
        end else if (ce) begin
            rp_s1_q <= bus.line_pos;
            rp_s2_q <= rp_s1_q;
            rn_s1_q <= bus.line_neg;
            rn_s2_q <= rn_s1_q;
        end
    end
    wire lvl = rp_s2_q; // high half when set
    wire act = rp_s2_q | rn_s2_q; // someone drives
    wire trans = act & act_q & (lvl ^ lvl_q); // zero crossing seen
    wire same = act & act_q & ~(lvl ^ lvl_q);
    // run length is the only way to tell a sync: no valid bit holds a level this long
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lvl_q <= 1'b0;
            act_q <= 1'b0;
            run_q <= '0;
        end else if (ce) begin
            lvl_q <= lvl;
            act_q <= act;
            run_q <= !same ? 9'h0 : (run_q == `CRBT_RUN_MAX) ? run_q : run_q + 9'h1;
        end
    end
    // ****************************************
    // receive decoder
    // ****************************************
    crbt_pkg::crbt_rx_e rx_q; // decoder state
    logic [8:0] cnt_q; // sample timer
    logic [4:0] nbit_q; // bits taken so far
    logic [16:0] sh_q; // payload and parity, msb first
    logic kind_q; // word began with a command sync
    logic tx_busy_q; // own transmitter running
    wire sync_seen = trans & (run_q >= `CRBT_SYNC_MIN_CNT) & ~tx_busy_q;
    wire wdone = (rx_q == crbt_pkg::CRBT_RX_MID) & trans & (nbit_q == `CRBT_WORD_BITS);
    wire par_ok = ^sh_q;
    // timing restarts at every mid-bit crossing, so only the far clock matters
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rx_q <= crbt_pkg::CRBT_RX_IDLE;
            cnt_q <= '0;
            nbit_q <= '0;
            sh_q <= '0;
            kind_q <= 1'b0;
        end else if (ce) begin
            unique case (rx_q)
                crbt_pkg::CRBT_RX_IDLE: begin
                    if (sync_seen) begin
                        kind_q <= lvl_q;
                        cnt_q <= `CRBT_SKIP_CNT;
                        nbit_q <= '0;
                        rx_q <= crbt_pkg::CRBT_RX_SAMP;
                    end
                end
                crbt_pkg::CRBT_RX_SAMP: begin
                    if (cnt_q == '0) begin
                        sh_q <= {sh_q[15:0], lvl};
                        nbit_q <= nbit_q + 5'h1;
                        cnt_q <= `CRBT_MID_WIN_CNT;
                        rx_q <= crbt_pkg::CRBT_RX_MID;
                    end else begin
                        cnt_q <= cnt_q - 9'h1;
                    end
                end
                crbt_pkg::CRBT_RX_MID: begin
                    if (trans) begin
                        cnt_q <= `CRBT_RESYNC_CNT;
                        rx_q <= wdone ? crbt_pkg::CRBT_RX_IDLE : crbt_pkg::CRBT_RX_SAMP;
                    end else if (cnt_q == '0) begin
                        // missing crossing: not manchester, drop the word
                        rx_q <= crbt_pkg::CRBT_RX_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 9'h1;
                    end
                end
                default: rx_q <= crbt_pkg::CRBT_RX_IDLE;
            endcase
        end
    end
    // ****************************************
    // role and command decode
    // ****************************************
    crbt_pkg::crbt_role_e role_q; // current role
    wire is_bc = role_q == crbt_pkg::CRBT_ROLE_BC;
    wire is_mon = role_q == crbt_pkg::CRBT_ROLE_MON;
    wire is_ru = ~is_bc & ~is_mon;
    wire [4:0] c_addr = sh_q[16:12];
    wire c_tr = sh_q[11];
    wire [4:0] c_sa = sh_q[10:6];
    wire [4:0] c_wc = sh_q[5:1];
    wire to_us = c_addr == my_addr;
    wire bc_hit = bcast_en & (c_addr == `CRBT_BCAST_ADDR);
    wire is_mode = (c_sa == `CRBT_MODE_SA0) | (c_sa == `CRBT_MODE_SA1);
    wire [5:0] nwords = is_mode ? {5'h0, c_wc[4]} :
                        (c_wc == 5'h0) ? `CRBT_MAX_WORDS : {1'b0, c_wc};
    wire cmd_ok = wdone & kind_q & par_ok & is_ru & (to_us | bc_hit);
    wire data_ok = wdone & ~kind_q & par_ok & is_ru;
    logic [5:0] grant_q; // words this unit may still send
    logic [5:0] exp_q; // data words still expected
    logic bcast_rx_q; // pending receive was broadcast, no status owed
    logic dbc_q; // control offer accepted, pending status
    wire tx_go; // transmitter takes a word
    // grant counting keeps a remote unit silent unless it was addressed
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            grant_q <= '0;
            exp_q <= '0;
            bcast_rx_q <= 1'b0;
        end else if (ce) begin
            if (cmd_ok) begin
                bcast_rx_q <= bc_hit;
                exp_q <= c_tr ? 6'h0 : nwords;
                if (bc_hit) grant_q <= '0;
                else if (c_tr) grant_q <= nwords + 6'h1;
                else grant_q <= (nwords == 6'h0) ? 6'h1 : 6'h0;
            end else if (data_ok && exp_q != '0) begin
                exp_q <= exp_q - 6'h1;
                if (exp_q == 6'h1 && !bcast_rx_q) grant_q <= 6'h1;
            end else if (tx_go && is_ru) begin
                grant_q <= grant_q - 6'h1;
            end
        end
    end
    // role register: set by software, promoted once a control offer is taken
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            role_q <= crbt_pkg::CRBT_ROLE_RU;
            dbc_q <= 1'b0;
        end else if (ce) begin
            if (role_set) begin
                role_q <= (role_sel == 2'b11) ? crbt_pkg::CRBT_ROLE_RU
                                              : crbt_pkg::crbt_role_e'(role_sel);
                dbc_q <= 1'b0;
            end else if (cmd_ok && is_mode && c_tr && to_us && c_wc == `CRBT_DBC_CODE) begin
                dbc_q <= dbc_accept;
            end else if (dbc_q && grant_q == '0 && !tx_busy_q) begin
                role_q <= crbt_pkg::CRBT_ROLE_BC;
                dbc_q <= 1'b0;
            end
        end
    end
    // ****************************************
    // reports to local logic
    // ****************************************
    // every word is reported in every role; the monitor simply never answers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rx_valid_q <= 1'b0;
            rx_word_q <= '0;
            rx_cmd_q <= 1'b0;
            rx_par_ok_q <= 1'b0;
            mode_stb_q <= 1'b0;
            mode_code_q <= '0;
            role_now_q <= 2'b00;
        end else if (ce) begin
            rx_valid_q <= wdone;
            if (wdone) begin
                rx_word_q <= sh_q[16:1];
                rx_cmd_q <= kind_q;
                rx_par_ok_q <= par_ok;
            end
            mode_stb_q <= cmd_ok & is_mode;
            if (cmd_ok && is_mode) mode_code_q <= c_wc;
            role_now_q <= role_q;
        end
    end
    // ****************************************
    // transmit path
    // ****************************************
    logic f_valid; // fifo has a word
    logic [16:0] f_data; // {is command, payload}
    crbt_fifo #(.W(17), .D(FIFO_DEPTH)) u_txq (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data({in_cmd, in_data}),
        .out_valid(f_valid),
        .out_ready(tx_go),
        .out_data(f_data)
    );
    // a monitor never drives; words wait in the fifo and back-pressure the user
    assign tx_go = f_valid & ~tx_busy_q & (rx_q == crbt_pkg::CRBT_RX_IDLE)
                   & ~act & ~act_q & (is_bc | (is_ru & grant_q != '0));
    logic [39:0] sym_q; // half-bit symbols, msb next
    logic [5:0] left_q; // halves left in the word
    logic [8:0] hcnt_q; // cycles left in this half
    logic pos_q, neg_q, oe_n_q; // pin registers
    // half-bit timer runs off the core clock only
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tx_busy_q <= 1'b0;
            sym_q <= '0;
            left_q <= '0;
            hcnt_q <= '0;
        end else if (ce) begin
            if (tx_go) begin
                sym_q <= crbt_pkg::crbt_encode(f_data[15:0], f_data[16]);
                left_q <= `CRBT_SYMS;
                hcnt_q <= `CRBT_HALF_CNT;
                tx_busy_q <= 1'b1;
            end else if (tx_busy_q && hcnt_q == '0) begin
                sym_q <= {sym_q[38:0], 1'b0};
                left_q <= left_q - 6'h1;
                hcnt_q <= `CRBT_HALF_CNT;
                tx_busy_q <= left_q != 6'h1;
            end else if (tx_busy_q) begin
                hcnt_q <= hcnt_q - 9'h1;
            end
        end
    end
    // pins follow the symbol register one cycle later
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pos_q <= 1'b0;
            neg_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else if (ce) begin
            pos_q <= tx_busy_q & sym_q[39];
            neg_q <= tx_busy_q & ~sym_q[39];
            oe_n_q <= ~tx_busy_q;
        end
    end
    assign bus.dev_pos = pos_q;
    assign bus.dev_neg = neg_q;
    assign bus.dev_oe_n = oe_n_q;
endmodule
`default_nettype wire

// ===== verification/crbt_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// link checks on the shared pair
// ****************************************
module crbt_monitor (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic dev_pos,
    input wire logic dev_neg,
    input wire logic dev_oe_n,
    input wire logic ctl_pos,
    input wire logic ctl_neg,
    input wire logic ctl_oe_n
);
    logic [12:0] dlen_q; // terminal drive length
    logic [12:0] clen_q; // controller drive length
    logic [6:0] run_q; // half-bit phase of controller drive
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // oe_n is high in reset, so no reset term is needed here
    always_ff @(posedge core_clk) begin
        dlen_q <= dev_oe_n ? 13'h0 : dlen_q + 13'h1;
        clen_q <= ctl_oe_n ? 13'h0 : clen_q + 13'h1;
        run_q <= (ctl_oe_n || run_q == 7'h7C) ? 7'h0 : run_q + 7'h1;
    end
    chk_no_collide: assert property (dev_oe_n || ctl_oe_n)
        else $error("both ends drive");
    chk_dev_legs: assert property (!dev_oe_n |-> dev_pos != dev_neg)
        else $error("terminal legs equal");
    chk_ctl_legs: assert property (!ctl_oe_n |-> ctl_pos != ctl_neg)
        else $error("controller legs equal");
    chk_ctl_half_bit: assert property (!ctl_oe_n && !$past(ctl_oe_n) && $changed(ctl_pos) |-> run_q == 7'h0)
        else $error("half bit length");
    // the drive length counters time the sync: one swap after 1.5 bits, none before 3
    chk_ctl_sync: assert property (!ctl_oe_n && clen_q != 13'h0 && clen_q < 13'h2EE |->
        $changed(ctl_pos) == (clen_q == 13'h177))
        else $error("controller sync shape");
    chk_dev_sync: assert property (!dev_oe_n && dlen_q != 13'h0 && dlen_q < 13'h2EE |->
        $changed(dev_pos) == (dlen_q == 13'h177))
        else $error("terminal sync shape");
    chk_ctl_word_len: assert property ($rose(ctl_oe_n) |-> clen_q == 13'h1388)
        else $error("controller word length");
    chk_dev_word_len: assert property ($rose(dev_oe_n) |-> dlen_q == 13'h1388)
        else $error("terminal word length");
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// both ends face each other on one pair
// ****************************************
module tb_top;
    logic core_clk = 1'b0; // 250 MHz
    logic sys_rst = 1'b1;
    logic role_set = 1'b0;
    logic in_valid = 1'b0;
    logic in_cmd = 1'b0;
    logic tx_valid = 1'b0;
    logic tx_cmd = 1'b0;
    logic [15:0] in_data = 16'h0;
    logic [15:0] tx_data = 16'h0;
    logic [1:0] role_sel = 2'h0;
    logic in_ready, tx_ready_q, t_rv, t_c, t_p, c_rv, c_c, c_p;
    logic [15:0] t_w, c_w, w;
    logic [1:0] role_now_q;
    logic [15:0] q [16]; // words queued at the terminal, status first
    integer seed = 10473;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    crbt_if bus ();
    always #2 core_clk = ~core_clk;
    crbt_terminal u_crbt_terminal (.core_clk(core_clk), .sys_rst(sys_rst), .ce(1'b1),
        .bus(bus), .role_sel(role_sel), .role_set(role_set), .my_addr(5'h0B),
        .bcast_en(1'b0), .dbc_accept(1'b0), .in_data(in_data), .in_cmd(in_cmd),
        .in_valid(in_valid), .in_ready(in_ready), .rx_valid_q(t_rv), .rx_word_q(t_w),
        .rx_cmd_q(t_c), .rx_par_ok_q(t_p), .mode_stb_q(), .mode_code_q(),
        .role_now_q(role_now_q));
    crbt_ctrl_end u_crbt_ctrl_end (.core_clk(core_clk), .sys_rst(sys_rst), .ce(1'b1),
        .bus(bus), .tx_data(tx_data), .tx_cmd(tx_cmd), .tx_valid(tx_valid),
        .tx_ready_q(tx_ready_q), .rx_valid_q(c_rv), .rx_word_q(c_w), .rx_cmd_q(c_c),
        .rx_par_ok_q(c_p));
    crbt_monitor u_crbt_monitor (.core_clk(core_clk), .sys_rst(sys_rst),
        .dev_pos(bus.dev_pos), .dev_neg(bus.dev_neg), .dev_oe_n(bus.dev_oe_n),
        .ctl_pos(bus.ctl_pos), .ctl_neg(bus.ctl_neg), .ctl_oe_n(bus.ctl_oe_n));
    // command word: address, transmit bit, subaddress, count
    function automatic logic [15:0] mk_cmd(input logic [4:0] a, input logic [4:0] n);
        return {a, 1'b1, 5'h01, n};
    endfunction
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic stop_test;
        if (num_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // request held until ready is seen at the same edge
    task automatic send(input logic [15:0] d, input logic c);
        tx_data <= d;
        tx_cmd <= c;
        tx_valid <= 1'b1;
        do @(posedge core_clk); while (tx_ready_q !== 1'b1);
        tx_valid <= 1'b0;
    endtask
    // the watchdog bounds this wait
    task automatic wait_rx(input logic term);
        do @(posedge core_clk); while ((term ? t_rv : c_rv) !== 1'b1);
    endtask
    // watchdog, about half again the expected run
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            stop_test();
        end
    end
    initial begin
        for (int i = 0; i < 16; i++) q[i] = 16'($random(seed));
        w = 16'($random(seed));
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        // monitor, then code 11 which must fold onto remote unit
        for (int i = 0; i < 2; i++) begin
            role_sel <= i ? 2'b11 : 2'b10;
            role_set <= 1'b1;
            @(posedge core_clk);
            role_set <= 1'b0;
            repeat (2) @(posedge core_clk);
            cmp("role", {14'h0, i ? 2'b00 : 2'b10}, {14'h0, role_now_q});
        end
        // fill the buffer with no grant: it must refuse, line stays quiet
        in_valid <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            in_data <= q[i];
            in_cmd <= (i == 0);
            do @(posedge core_clk); while (in_ready !== 1'b1);
        end
        in_valid <= 1'b0;
        repeat (200) @(posedge core_clk);
        cmp("in_ready", 16'h0, {15'h0, in_ready});
        cmp("dev_oe_n", 16'h1, {15'h0, bus.dev_oe_n});
        send(w, 1'b0);
        wait_rx(1'b1);
        cmp("t_word", w, t_w);
        cmp("t_cmd", 16'h0, {15'h0, t_c});
        cmp("t_par", 16'h1, {15'h0, t_p});
        // transmit command for one word: status then one data word
        send(mk_cmd(5'h0B, 5'h01), 1'b1);
        wait_rx(1'b1);
        cmp("t_cmd", 16'h1, {15'h0, t_c});
        wait_rx(1'b0);
        cmp("c_word", q[0], c_w);
        cmp("c_cmd", 16'h1, {15'h0, c_c});
        wait_rx(1'b0);
        cmp("c_word", q[1], c_w);
        cmp("c_par", 16'h1, {15'h0, c_p});
        repeat (6000) @(posedge core_clk);
        cmp("dev_oe_n", 16'h1, {15'h0, bus.dev_oe_n});
        cmp("in_ready", 16'h1, {15'h0, in_ready});
        stop_test();
    end
endmodule
`default_nettype wire
